// *** rtl/pmt_core_timing.sv ***
// Opcode decoder and cycle sequencer of the pipelined core.
`timescale 1ns/10ps
`default_nettype none

module pmt_core_timing
  import pmt_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Instruction issue
  input  wire logic              inst_valid,
  input  wire logic [OPC_W-1:0]  inst_opcode,
  input  wire logic              branch_taken,
  output var  logic              inst_ready_q,
  // Decode result of the accepted instruction
  output var  logic [OPC_W-1:0]  dec_opcode_q,
  output var  logic [LEN_W-1:0]  dec_len_q,
  output var  logic [CYC_W-1:0]  dec_cycles_q,
  output var  logic              dec_cond_q,
  output var  logic              dec_illegal_q,
  output var  logic [2:0]        dec_class_q,
  // Execution status
  output var  logic              exec_busy_q,
  output var  logic              inst_done_q,
  output var  logic [CYC_W-1:0]  cycles_left_q,
  // Throughput statistics
  input  wire logic              perf_clear,
  output var  logic [PERF_W-1:0] perf_cycles_q,
  output var  logic [PERF_W-1:0] perf_retired_q
);

  // ==========================================================================
  // Opcode decode table
  // ==========================================================================
  function automatic pmt_dec_s decode(input logic [OPC_W-1:0] op);
    pmt_dec_s d;
    logic [3:0] hi;
    logic [3:0] lo;
    d  = '{len: LEN_1, cyc: CYC_1, cond: 1'b0, illegal: 1'b0, cls: CLS_MOVE};
    hi = op[7:4];
    lo = op[3:0];
    if (lo >= 4'h8) begin
      // Working register operand.
      d.cls = (hi <= 4'h3 || hi == 4'h9) ? CLS_ARITH : CLS_LOGIC;
      case (hi)
        4'h7, 4'h8, 4'ha: begin
          d = '{len: LEN_2, cyc: CYC_2, cond: 1'b0, illegal: 1'b0,
                cls: CLS_MOVE};
        end
        4'hb: begin
          d = '{len: LEN_3, cyc: CYC_3, cond: 1'b1, illegal: 1'b0,
                cls: CLS_BRANCH};
        end
        4'hd: begin
          d = '{len: LEN_2, cyc: CYC_2, cond: 1'b1, illegal: 1'b0,
                cls: CLS_BRANCH};
        end
        default: begin
          d.len = LEN_1;
          d.cyc = CYC_1;
        end
      endcase
    end else if (lo >= 4'h6) begin
      // Indirect RAM operand.
      d.len = LEN_1;
      d.cyc = CYC_2;
      d.cls = (hi <= 4'h3 || hi == 4'h9) ? CLS_ARITH : CLS_LOGIC;
      case (hi)
        4'h7, 4'h8, 4'ha: begin
          d.len = LEN_2;
          d.cls = CLS_MOVE;
        end
        4'hb: begin
          d = '{len: LEN_3, cyc: CYC_4, cond: 1'b1, illegal: 1'b0,
                cls: CLS_BRANCH};
        end
        default: begin
          d.cyc = CYC_2;
        end
      endcase
    end else if (lo == 4'h5) begin
      // Direct byte operand.
      d.len = LEN_2;
      d.cyc = CYC_2;
      d.cls = (hi <= 4'h3 || hi == 4'h9) ? CLS_ARITH : CLS_LOGIC;
      case (hi)
        4'h7, 4'h8: begin
          d.len = LEN_3;
          d.cyc = CYC_3;
          d.cls = CLS_MOVE;
        end
        4'ha: begin
          d = '{len: LEN_1, cyc: CYC_1, cond: 1'b0, illegal: 1'b1,
                cls: CLS_NOP};
        end
        4'hb: begin
          d = '{len: LEN_3, cyc: CYC_4, cond: 1'b1, illegal: 1'b0,
                cls: CLS_BRANCH};
        end
        4'hd: begin
          d = '{len: LEN_3, cyc: CYC_3, cond: 1'b1, illegal: 1'b0,
                cls: CLS_BRANCH};
        end
        default: begin
          d.cyc = CYC_2;
        end
      endcase
    end else if (lo == 4'h4) begin
      // Immediate and accumulator-only forms.
      d.len = LEN_2;
      d.cyc = CYC_2;
      d.cls = CLS_ARITH;
      case (hi)
        4'h0, 4'h1, 4'hc, 4'hd, 4'he, 4'hf: begin
          d.len = LEN_1;
          d.cyc = CYC_1;
        end
        4'h8: begin
          d = '{len: LEN_1, cyc: CYC_DIV, cond: 1'b0, illegal: 1'b0,
                cls: CLS_MULDIV};
        end
        4'ha: begin
          d = '{len: LEN_1, cyc: CYC_MUL, cond: 1'b0, illegal: 1'b0,
                cls: CLS_MULDIV};
        end
        4'hb: begin
          d = '{len: LEN_3, cyc: CYC_3, cond: 1'b1, illegal: 1'b0,
                cls: CLS_BRANCH};
        end
        default: begin
          d.cls = (hi >= 4'h4 && hi <= 4'h6) ? CLS_LOGIC : CLS_ARITH;
        end
      endcase
    end else if (lo == 4'h3) begin
      case (hi)
        4'h4, 4'h5, 4'h6: begin
          d.len = LEN_3;
          d.cyc = CYC_3;
          d.cls = CLS_LOGIC;
        end
        4'h7: begin
          d.cyc = CYC_3;
          d.cls = CLS_BRANCH;
        end
        4'h8, 4'h9, 4'he, 4'hf: begin
          d.cyc = CYC_3;
        end
        4'hb, 4'hc, 4'hd: begin
          d.cls = CLS_BOOL;
        end
        default: begin
          d.cls = (hi == 4'ha) ? CLS_ARITH : CLS_LOGIC;
        end
      endcase
    end else if (lo == 4'h2) begin
      d.len = LEN_2;
      d.cyc = CYC_2;
      d.cls = CLS_BOOL;
      case (hi)
        4'h0, 4'h1: begin
          d = '{len: LEN_3, cyc: CYC_4, cond: 1'b0, illegal: 1'b0,
                cls: CLS_BRANCH};
        end
        4'h2, 4'h3: begin
          d = '{len: LEN_1, cyc: CYC_5, cond: 1'b0, illegal: 1'b0,
                cls: CLS_BRANCH};
        end
        4'h4, 4'h5, 4'h6: begin
          d.cls = CLS_LOGIC;
        end
        4'he, 4'hf: begin
          d = '{len: LEN_1, cyc: CYC_3, cond: 1'b0, illegal: 1'b0,
                cls: CLS_MOVE};
        end
        default: begin
          d.cyc = CYC_2;
        end
      endcase
    end else if (lo == 4'h1) begin
      // Absolute jump or call.
      d = '{len: LEN_2, cyc: CYC_3, cond: 1'b0, illegal: 1'b0,
            cls: CLS_BRANCH};
    end else begin
      case (hi)
        4'h0: begin
          d.cls = CLS_NOP;
        end
        4'h1, 4'h2, 4'h3: begin
          d = '{len: LEN_3, cyc: CYC_3, cond: 1'b1, illegal: 1'b0,
                cls: CLS_BRANCH};
        end
        4'h4, 4'h5, 4'h6, 4'h7: begin
          d = '{len: LEN_2, cyc: CYC_2, cond: 1'b1, illegal: 1'b0,
                cls: CLS_BRANCH};
        end
        4'h8: begin
          d = '{len: LEN_2, cyc: CYC_3, cond: 1'b0, illegal: 1'b0,
                cls: CLS_BRANCH};
        end
        4'h9: begin
          d.len = LEN_3;
          d.cyc = CYC_3;
        end
        4'ha, 4'hb: begin
          d.len = LEN_2;
          d.cyc = CYC_2;
          d.cls = CLS_BOOL;
        end
        4'hc, 4'hd: begin
          d.len = LEN_2;
          d.cyc = CYC_2;
        end
        default: begin
          d.cyc = CYC_3;
        end
      endcase
    end
    return d;
  endfunction : decode

  // ==========================================================================
  // Issue decode
  // ==========================================================================
  pmt_dec_s         dec;
  logic             accept;
  logic [CYC_W-1:0] total_cyc;

  always_comb begin
    dec       = decode(inst_opcode);
    accept    = inst_valid && inst_ready_q;
    total_cyc = dec.cyc;
    if (dec.cond && branch_taken) begin
      total_cyc = dec.cyc + CYC_TAKEN_EXTRA;
    end
    if (total_cyc > CYC_MAX) begin
      total_cyc = CYC_MAX;
    end
  end

  // ==========================================================================
  // Cycle counting
  // ==========================================================================
  logic [CYC_W-1:0] left_q;

  pmt_down_counter #(
    .W (CYC_W)
  ) u_left (
    .clk      (clk),
    .nrst     (nrst),
    .load     (accept),
    .load_val (total_cyc),
    .count_q  (left_q)
  );

  pmt_event_counter #(
    .W (PERF_W)
  ) u_perf_cycles (
    .clk     (clk),
    .nrst    (nrst),
    .clear   (perf_clear),
    .inc     (1'b1),
    .count_q (perf_cycles_q)
  );

  pmt_event_counter #(
    .W (PERF_W)
  ) u_perf_retired (
    .clk     (clk),
    .nrst    (nrst),
    .clear   (perf_clear),
    .inc     (inst_done_q),
    .count_q (perf_retired_q)
  );

  // ==========================================================================
  // Sequencer next state
  // ==========================================================================
  pmt_state_e       state_q;
  pmt_state_e       state_d;
  logic [CYC_W-1:0] left_d;
  logic             ready_d;
  logic             done_d;
  logic [OPC_W-1:0] opcode_d;
  logic [LEN_W-1:0] len_d;
  logic [CYC_W-1:0] cycles_d;
  logic             cond_d;
  logic             illegal_d;
  logic [2:0]       class_d;

  always_comb begin
    state_d   = state_q;
    opcode_d  = dec_opcode_q;
    len_d     = dec_len_q;
    cycles_d  = dec_cycles_q;
    cond_d    = dec_cond_q;
    illegal_d = dec_illegal_q;
    class_d   = dec_class_q;
    left_d    = (left_q != CYC_RST) ? left_q - CYC_1 : CYC_RST;
    done_d    = (left_q == CYC_1);
    if (accept) begin
      left_d    = total_cyc;
      opcode_d  = inst_opcode;
      len_d     = dec.len;
      cycles_d  = total_cyc;
      cond_d    = dec.cond;
      illegal_d = dec.illegal;
      class_d   = dec.cls;
    end
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (left_d == CYC_RST) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    ready_d = (left_d <= CYC_1);
  end

  // ==========================================================================
  // Sequencer registers
  // ==========================================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q       <= ST_IDLE;
      inst_ready_q  <= 1'b1;
      inst_done_q   <= 1'b0;
      exec_busy_q   <= 1'b0;
      cycles_left_q <= CYC_RST;
      dec_opcode_q  <= OPC_RST;
      dec_len_q     <= LEN_RST;
      dec_cycles_q  <= CYC_RST;
      dec_cond_q    <= 1'b0;
      dec_illegal_q <= 1'b0;
      dec_class_q   <= 3'h0;
    end else begin
      state_q       <= state_d;
      inst_ready_q  <= ready_d;
      inst_done_q   <= done_d;
      exec_busy_q   <= (state_d == ST_EXEC);
      cycles_left_q <= left_d;
      dec_opcode_q  <= opcode_d;
      dec_len_q     <= len_d;
      dec_cycles_q  <= cycles_d;
      dec_cond_q    <= cond_d;
      dec_illegal_q <= illegal_d;
      dec_class_q   <= class_d;
    end
  end

endmodule : pmt_core_timing

`default_nettype wire

// *** rtl/pmt_down_counter.sv ***
// Loadable down counter that tracks the cycles left of an instruction.
`timescale 1ns/10ps
`default_nettype none

module pmt_down_counter #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // State
  output var  logic [W-1:0] count_q
);

  logic [W-1:0] count_d;

  // ==========================================================================
  // Next value
  // ==========================================================================
  always_comb begin
    count_d = count_q;
    if (load) begin
      count_d = load_val;
    end else if (count_q != '0) begin
      count_d = count_q - W'(1);
    end
  end

  // ==========================================================================
  // Register
  // ==========================================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule : pmt_down_counter

`default_nettype wire

// *** rtl/pmt_event_counter.sv ***
// Free-running event counter used for throughput statistics.
`timescale 1ns/10ps
`default_nettype none

module pmt_event_counter #(
  parameter int unsigned W = 32
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Control
  input  wire logic         clear,
  input  wire logic         inc,
  // State
  output var  logic [W-1:0] count_q
);

  logic [W-1:0] count_d;

  // ==========================================================================
  // Next value
  // ==========================================================================
  always_comb begin
    count_d = count_q;
    if (clear) begin
      count_d = '0;
    end else if (inc) begin
      count_d = count_q + W'(1);
    end
  end

  // ==========================================================================
  // Register
  // ==========================================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule : pmt_event_counter

`default_nettype wire

// *** rtl/pmt_pkg.sv ***
// Shared constants and types for the instruction timing block.
package pmt_pkg;

  // ==========================================================================
  // Clocking and timing limits
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned SYS_CLK_MIN_MHZ = 10;
  localparam int unsigned SYS_CLK_MAX_MHZ = 24;
  localparam int unsigned PEAK_MIPS       = 24;

  // ==========================================================================
  // Field widths
  // ==========================================================================
  localparam int unsigned OPC_W  = 8;
  localparam int unsigned LEN_W  = 2;
  localparam int unsigned CYC_W  = 4;
  localparam int unsigned PERF_W = 32;

  // ==========================================================================
  // Instruction lengths in program bytes
  // ==========================================================================
  localparam logic [LEN_W-1:0] LEN_1 = 2'h1;
  localparam logic [LEN_W-1:0] LEN_2 = 2'h2;
  localparam logic [LEN_W-1:0] LEN_3 = 2'h3;

  // ==========================================================================
  // Execution times in clock cycles
  // ==========================================================================
  localparam logic [CYC_W-1:0] CYC_1    = 4'h1;
  localparam logic [CYC_W-1:0] CYC_2    = 4'h2;
  localparam logic [CYC_W-1:0] CYC_3    = 4'h3;
  localparam logic [CYC_W-1:0] CYC_4    = 4'h4;
  localparam logic [CYC_W-1:0] CYC_5    = 4'h5;
  localparam logic [CYC_W-1:0] CYC_MUL  = 4'h4;
  localparam logic [CYC_W-1:0] CYC_DIV  = 4'h8;
  localparam logic [CYC_W-1:0] CYC_MAX  = 4'h8;
  localparam logic [CYC_W-1:0] CYC_TAKEN_EXTRA = 4'h1;

  // ==========================================================================
  // Instruction set census
  // ==========================================================================
  localparam int unsigned NUM_INSTR      = 109;
  localparam int unsigned NUM_INSTR_CYC1 = 26;
  localparam int unsigned NUM_INSTR_CYC2 = 50;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [OPC_W-1:0] OPC_RST  = 8'h00;
  localparam logic [CYC_W-1:0] CYC_RST  = 4'h0;
  localparam logic [LEN_W-1:0] LEN_RST  = 2'h0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    CLS_NOP,
    CLS_ARITH,
    CLS_LOGIC,
    CLS_MOVE,
    CLS_BOOL,
    CLS_BRANCH,
    CLS_MULDIV
  } pmt_class_e;

  typedef struct packed {
    logic [LEN_W-1:0] len;
    logic [CYC_W-1:0] cyc;
    logic             cond;
    logic             illegal;
    pmt_class_e       cls;
  } pmt_dec_s;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } pmt_state_e;

endpackage : pmt_pkg

// *** verification/pmt_core_timing_chk.sv ***
// Concurrent checks on the ports of the instruction timing block.
`timescale 1ns/10ps
`default_nettype none

module pmt_core_timing_chk
  import pmt_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // Instruction issue
  input wire logic              inst_valid,
  input wire logic [OPC_W-1:0]  inst_opcode,
  input wire logic              branch_taken,
  input wire logic              inst_ready_q,
  // Decode result
  input wire logic [OPC_W-1:0]  dec_opcode_q,
  input wire logic [LEN_W-1:0]  dec_len_q,
  input wire logic [CYC_W-1:0]  dec_cycles_q,
  input wire logic              dec_cond_q,
  input wire logic              dec_illegal_q,
  input wire logic [2:0]        dec_class_q,
  // Execution status
  input wire logic              exec_busy_q,
  input wire logic              inst_done_q,
  input wire logic [CYC_W-1:0]  cycles_left_q,
  // Statistics
  input wire logic              perf_clear,
  input wire logic [PERF_W-1:0] perf_cycles_q,
  input wire logic [PERF_W-1:0] perf_retired_q
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  logic take;
  assign take = inst_valid && inst_ready_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  take_load_a: assert property (take |=>
    (dec_opcode_q == $past(inst_opcode))
    && (cycles_left_q == dec_cycles_q) && exec_busy_q)
    else $error("Decode not loaded on take.");
  count_down_a: assert property ((cycles_left_q > 4'h1) |=>
    (cycles_left_q == $past(cycles_left_q) - 4'h1))
    else $error("Cycle count not decremented.");
  last_done_a: assert property ((cycles_left_q == 4'h1) |=>
    inst_done_q)
    else $error("Done missing after last cycle.");
  ready_low_a: assert property ((cycles_left_q > 4'h1) |->
    !inst_ready_q)
    else $error("Ready high with cycles pending.");
  one_per_clk_a: assert property ((take && inst_opcode == 8'h28)
    |=> inst_ready_q ##1 inst_done_q)
    else $error("One cycle instruction not retired in one clock.");
  max_cyc_a: assert property (exec_busy_q |->
    (cycles_left_q <= CYC_MAX) && (dec_cycles_q <= CYC_MAX))
    else $error("Cycle count above eight.");
  branch_cnt_a: assert property ((take && inst_opcode == 8'h60) |=>
    dec_cond_q && (dec_cycles_q == ($past(branch_taken) ? CYC_3 : CYC_2)))
    else $error("Branch cycle count wrong.");
  rn_one_a: assert property ((take && inst_opcode[7:3] inside
    {5'h05, 5'h07, 5'h09, 5'h0b, 5'h0d, 5'h13}) |=>
    (dec_len_q == LEN_1) && (dec_cycles_q == CYC_1))
    else $error("Register operand timing wrong.");
  ind_two_a: assert property ((take && inst_opcode inside
    {8'h26, 8'h27, 8'h96, 8'h97}) |=>
    (dec_len_q == LEN_1) && (dec_cycles_q == CYC_2))
    else $error("Indirect operand timing wrong.");
  logic_imm_a: assert property ((take && inst_opcode inside
    {8'h43, 8'h53, 8'h63}) |=> (dec_len_q == LEN_3)
    && (cycles_left_q == CYC_3) ##3 inst_done_q)
    else $error("Direct immediate logic timing wrong.");
  mul_time_a: assert property ((take && inst_opcode == 8'ha4) |=>
    (cycles_left_q == CYC_MUL) ##4 inst_done_q)
    else $error("Multiply timing wrong.");
  div_time_a: assert property ((take && inst_opcode == 8'h84) |=>
    (cycles_left_q == CYC_DIV) ##8 inst_done_q)
    else $error("Divide timing wrong.");

  // ==========================================================================
  // Coverage
  // ==========================================================================
  div_c: cover property (take && inst_opcode == 8'h84);
  burst_c: cover property (inst_done_q ##1 inst_done_q ##1 inst_done_q);
  taken_c: cover property (take && inst_opcode == 8'h60 && branch_taken);
endmodule : pmt_core_timing_chk

`default_nettype wire

// *** verification/pmt_fetch_model.sv ***
// Program memory model that issues opcodes and holds each until taken.
`timescale 1ns/10ps
`default_nettype none

module pmt_fetch_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Issue handshake
  input  wire logic       inst_ready_q,
  output var  logic       inst_valid,
  output var  logic [7:0] inst_opcode,
  output var  logic       branch_taken
);
  logic [8:0] fifo[$];
  int         gap;
  int         wait_cnt;

  task automatic push(input logic [7:0] opc, input logic tk);
    fifo.push_back({tk, opc});
  endtask : push

  initial begin
    inst_valid = 1'b0;
    inst_opcode = 8'h00;
    branch_taken = 1'b0;
    gap = 0;
    wait_cnt = 0;
  end

  // Idle cycles show a changing pattern so that stale opcodes are not reused.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fifo.delete();
      wait_cnt = 0;
      inst_valid = 1'b0;
    end else begin
      if (inst_valid && inst_ready_q) begin
        void'(fifo.pop_front());
        wait_cnt = gap;
      end
      #1;
      if (fifo.size() > 0 && wait_cnt == 0) begin
        inst_valid = 1'b1;
        {branch_taken, inst_opcode} = fifo[0];
      end else begin
        if (wait_cnt > 0) wait_cnt--;
        inst_valid = 1'b0;
        inst_opcode = ~inst_opcode;
        branch_taken = ~branch_taken;
      end
    end
  end
endmodule : pmt_fetch_model

`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking testbench of the instruction timing block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("Error t=%0t got=%0h exp=%0h", $time, g, e); end end

module tb_top
  import pmt_pkg::*;
;
  logic clk, nrst, perf_clear, inst_valid, branch_taken, inst_ready_q;
  logic dec_cond_q, dec_illegal_q, exec_busy_q, inst_done_q;
  logic [7:0] inst_opcode, dec_opcode_q;
  logic [1:0] dec_len_q;
  logic [3:0] dec_cycles_q, cycles_left_q;
  logic [2:0] dec_class_q;
  logic [31:0] perf_cycles_q, perf_retired_q;
  int errors, num_checks;

  // ==========================================================================
  // Instances
  // ==========================================================================
  pmt_core_timing pmt_core_timing_i (.clk(clk), .nrst(nrst),
    .inst_valid(inst_valid), .inst_opcode(inst_opcode),
    .branch_taken(branch_taken), .inst_ready_q(inst_ready_q),
    .dec_opcode_q(dec_opcode_q), .dec_len_q(dec_len_q),
    .dec_cycles_q(dec_cycles_q), .dec_cond_q(dec_cond_q),
    .dec_illegal_q(dec_illegal_q), .dec_class_q(dec_class_q),
    .exec_busy_q(exec_busy_q), .inst_done_q(inst_done_q),
    .cycles_left_q(cycles_left_q), .perf_clear(perf_clear),
    .perf_cycles_q(perf_cycles_q), .perf_retired_q(perf_retired_q));
  pmt_fetch_model pmt_fetch_model_i (.clk(clk), .nrst(nrst),
    .inst_ready_q(inst_ready_q), .inst_valid(inst_valid),
    .inst_opcode(inst_opcode), .branch_taken(branch_taken));

  always #5 clk = ~clk;

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic give_verdict;
    $display("Checks made %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic wait_take;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(inst_valid === 1'b1 && inst_ready_q === 1'b1) && n < 50);
    if (n >= 50) errors++;
    #1;
  endtask : wait_take

  task automatic run_one(input logic [7:0] opc, input logic tk,
                         input logic [1:0] len, input logic [3:0] cyc,
                         input logic cond);
    int n;
    pmt_fetch_model_i.push(opc, tk);
    wait_take();
    `CHK(dec_opcode_q, opc)
    `CHK(dec_len_q, len)
    `CHK(dec_cycles_q, cyc)
    `CHK(dec_cond_q, cond)
    n = 0;
    while (inst_done_q !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n[7:0], {4'h0, cyc})
  endtask : run_one

  task automatic t_reset;
    `CHK(inst_ready_q, 1'b1)
    `CHK({exec_busy_q, inst_done_q, cycles_left_q}, 6'h00)
    `CHK(perf_retired_q, 32'h0)
  endtask : t_reset

  task automatic t_table;
    pmt_fetch_model_i.gap = 1;
    run_one(8'h28, 1'b0, LEN_1, CYC_1, 1'b0);
    run_one(8'h58, 1'b0, LEN_1, CYC_1, 1'b0);
    run_one(8'h98, 1'b0, LEN_1, CYC_1, 1'b0);
    run_one(8'h25, 1'b0, LEN_2, CYC_2, 1'b0);
    run_one(8'h55, 1'b0, LEN_2, CYC_2, 1'b0);
    run_one(8'h26, 1'b0, LEN_1, CYC_2, 1'b0);
    run_one(8'h67, 1'b0, LEN_1, CYC_2, 1'b0);
    run_one(8'h24, 1'b0, LEN_2, CYC_2, 1'b0);
    run_one(8'h44, 1'b0, LEN_2, CYC_2, 1'b0);
    run_one(8'h53, 1'b0, LEN_3, CYC_3, 1'b0);
    run_one(8'h63, 1'b0, LEN_3, CYC_3, 1'b0);
    run_one(8'ha4, 1'b0, LEN_1, CYC_MUL, 1'b0);
    run_one(8'h84, 1'b0, LEN_1, CYC_DIV, 1'b0);
    `CHK(dec_class_q, CLS_MULDIV)
    run_one(8'h60, 1'b0, LEN_2, CYC_2, 1'b1);
    run_one(8'h60, 1'b1, LEN_2, CYC_3, 1'b1);
    `CHK(dec_class_q, CLS_BRANCH)
    run_one(8'hb5, 1'b0, LEN_3, CYC_4, 1'b1);
    run_one(8'hb5, 1'b1, LEN_3, CYC_5, 1'b1);
    run_one(8'h20, 1'b1, LEN_3, CYC_4, 1'b1);
    run_one(8'h22, 1'b0, LEN_1, CYC_5, 1'b0);
    run_one(8'h02, 1'b0, LEN_3, CYC_4, 1'b0);
    run_one(8'h85, 1'b0, LEN_3, CYC_3, 1'b0);
    run_one(8'h00, 1'b0, LEN_1, CYC_1, 1'b0);
    `CHK({dec_illegal_q, dec_class_q}, {1'b0, CLS_NOP})
    run_one(8'ha5, 1'b0, LEN_1, CYC_1, 1'b0);
    `CHK({dec_illegal_q, dec_class_q}, {1'b1, CLS_NOP})
    pmt_fetch_model_i.gap = 0;
  endtask : t_table

  task automatic t_burst;
    logic [31:0] r0;
    repeat (8) pmt_fetch_model_i.push(8'h28, 1'b0);
    wait_take();
    r0 = perf_retired_q;
    repeat (8) begin
      @(posedge clk);
      #1;
      `CHK(inst_done_q, 1'b1)
    end
    @(posedge clk);
    #1;
    `CHK(inst_done_q, 1'b0)
    `CHK(perf_retired_q, r0 + 32'h8)
  endtask : t_burst

  task automatic t_refuse;
    pmt_fetch_model_i.push(8'ha4, 1'b0);
    pmt_fetch_model_i.push(8'h28, 1'b0);
    wait_take();
    repeat (3) begin
      `CHK({inst_ready_q, dec_opcode_q}, 9'h0a4)
      @(posedge clk);
      #1;
    end
    `CHK(inst_ready_q, 1'b1)
    @(posedge clk);
    #1;
    `CHK({inst_done_q, dec_opcode_q}, 9'h128)
    repeat (2) @(posedge clk);
    #1;
  endtask : t_refuse

  task automatic t_perf;
    perf_clear = 1'b1;
    @(posedge clk);
    #1;
    perf_clear = 1'b0;
    `CHK(perf_cycles_q, 32'h0)
    repeat (5) @(posedge clk);
    #1;
    `CHK({perf_cycles_q, perf_retired_q}, {32'h5, 32'h0})
  endtask : t_perf

  // ==========================================================================
  // Sequence and watchdog
  // ==========================================================================
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    perf_clear = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    t_reset();
    nrst = 1'b1;
    t_table();
    t_burst();
    t_refuse();
    t_perf();
    give_verdict();
  end

  initial begin
    #100000;
    errors++;
    give_verdict();
  end
endmodule : tb_top

bind pmt_core_timing pmt_core_timing_chk pmt_core_timing_chk_i (
  .clk(clk), .nrst(nrst), .inst_valid(inst_valid),
  .inst_opcode(inst_opcode), .branch_taken(branch_taken),
  .inst_ready_q(inst_ready_q), .dec_opcode_q(dec_opcode_q),
  .dec_len_q(dec_len_q), .dec_cycles_q(dec_cycles_q),
  .dec_cond_q(dec_cond_q), .dec_illegal_q(dec_illegal_q),
  .dec_class_q(dec_class_q), .exec_busy_q(exec_busy_q),
  .inst_done_q(inst_done_q), .cycles_left_q(cycles_left_q),
  .perf_clear(perf_clear), .perf_cycles_q(perf_cycles_q),
  .perf_retired_q(perf_retired_q));

`default_nettype wire
